// [ditd_consts.vh]
`ifndef DITD_CONSTS_VH
`define DITD_CONSTS_VH
// Register byte addresses
`define DITD_ADDR_MODE      12'h000
`define DITD_ADDR_FUNC1     12'h004
`define DITD_ADDR_FUNC2     12'h008
`define DITD_ADDR_FUNC3     12'h00c
`define DITD_ADDR_FUNC4     12'h010
`define DITD_ADDR_FUNC5     12'h014
`define DITD_ADDR_CTRL      12'h018
`define DITD_ADDR_STATUS    12'h01c
`define DITD_ADDR_CMD       12'h020
// Ranges and reset values
`define DITD_MODE_MAX       8'h02
`define DITD_FUNC_MAX       8'h1c
`define DITD_RST_VAL        8'h00
// Wiring modes
`define DITD_MODE_TWO_A     8'h00
`define DITD_MODE_TWO_B     8'h01
`define DITD_MODE_THREE     8'h02
// Terminal function codes
`define DITD_F_NONE         8'h00
`define DITD_F_STEP0        8'h01
`define DITD_F_STEP1        8'h02
`define DITD_F_STEP2        8'h03
`define DITD_F_RAMP0        8'h05
`define DITD_F_RAMP1        8'h06
`define DITD_F_THREEWIRE    8'h07
`define DITD_F_COAST        8'h08
`define DITD_F_UP           8'h09
`define DITD_F_DOWN         8'h0a
`define DITD_F_ZERO         8'h0b
`define DITD_F_DCBRAKE      8'h0d
`define DITD_F_SEQINH       8'h0f
`define DITD_F_SEQPAUSE     8'h10
`define DITD_F_FSRC2        8'h12
`define DITD_F_EXTNO        8'h13
`define DITD_F_EXTNC        8'h14
`define DITD_F_FWD          8'h17
`define DITD_F_REV          8'h18
// Debounce: 1 us stable time at 4 ns period
`define DITD_DEB_NS         1000
`define DITD_CLK_NS         4
`define DITD_DEB_CYC        (`DITD_DEB_NS / `DITD_CLK_NS)
`define DITD_DEB_W          8
// Ctrl bits
`define DITD_CTRL_POL       0
`define DITD_CTRL_STOPM     1
`define DITD_CTRL_SEQCFG    2
`define DITD_CTRL_CLRWARN   3
`endif

// [ditd_input_decoder.v]
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "ditd_consts.vh"
module ditd_input_decoder (
	input  wire        mclk,
	input  wire        nrst,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire [4:0]  terminalIn,
	output reg         runCmd,
	output reg         reverseDir,
	output reg         fwdLamp,
	output reg         revLamp,
	output reg         coastStop,
	output reg         rampStop,
	output reg  [2:0]  speedStep,
	output reg  [1:0]  rampSet,
	output reg         setpointUp,
	output reg         setpointDown,
	output reg         setpointZero,
	output reg         dcBrakeEnable,
	output reg         seqRunning,
	output reg         seqPause,
	output reg         seqRestart,
	output reg         freqSource2,
	output reg         externalFaultError,
	output reg         paramConflictWarning
);

	reg  [7:0]  modeReg;
	reg  [7:0]  funcReg [0:4];
	reg  [3:0]  ctrlReg;
	reg  [4:0]  sync1Reg;
	reg  [4:0]  sync2Reg;
	reg  [4:0]  debReg;
	reg  [7:0]  debCnt [0:4];
	reg         runLevelReg;
	reg         inhLatchReg;
	reg         seqRunReg;
	wire [4:0]  act;
	wire        wrEn;
	wire        rdEn;
	integer     i;
	integer     j;

	// Terminal active level for a function code, zero when unmapped
	function anyFunc;
		input [7:0] code;
		input [4:0] lv;
		input [39:0] fn;
		integer k;
		begin
			anyFunc = 1'b0;
			for (k = 0; k < 5; k = k + 1) begin
				if (fn[k*8 +: 8] == code && lv[k])
					anyFunc = 1'b1;
			end
		end
	endfunction

	// Is the code mapped on any terminal at all
	function mapped;
		input [7:0] code;
		input [39:0] fn;
		integer k;
		begin
			mapped = 1'b0;
			for (k = 0; k < 5; k = k + 1) begin
				if (fn[k*8 +: 8] == code)
					mapped = 1'b1;
			end
		end
	endfunction

	wire [39:0] fnVec = {funcReg[4], funcReg[3], funcReg[2], funcReg[1], funcReg[0]};

	// APB: zero wait states, unmapped reads give zero and raise no error
	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	assign wrEn    = psel & penable & pwrite;
	assign rdEn    = psel & ~penable & ~pwrite;

	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sync1Reg <= 5'h00;
			sync2Reg <= 5'h00;
		end else begin
			sync1Reg <= terminalIn;
			sync2Reg <= sync1Reg;
		end
	end

	// Debounce: level must stay for the stable time
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			debReg <= 5'h00;
			for (i = 0; i < 5; i = i + 1)
				debCnt[i] <= 8'h00;
		end else begin
			for (i = 0; i < 5; i = i + 1) begin
				if (sync2Reg[i] == debReg[i])
					debCnt[i] <= 8'h00;
				else if (debCnt[i] == `DITD_DEB_CYC - 1) begin
					debReg[i] <= sync2Reg[i];
					debCnt[i] <= 8'h00;
				end else
					debCnt[i] <= debCnt[i] + 8'h01;
			end
		end
	end

	// Polarity type: sinking inputs are inverted
	assign act = ctrlReg[`DITD_CTRL_POL] ? ~debReg : debReg;

	wire [4:0] fnMatch3w;
	genvar g;
	generate
		for (g = 0; g < 5; g = g + 1) begin : gMap
			assign fnMatch3w[g] = (funcReg[g] == `DITD_F_THREEWIRE);
		end
	endgenerate

	// Register writes with range and conflict checks
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			modeReg <= `DITD_RST_VAL;
			ctrlReg <= 4'h0;
			paramConflictWarning <= 1'b0;
			for (j = 0; j < 5; j = j + 1)
				funcReg[j] <= `DITD_RST_VAL;
		end else begin
			if (wrEn && paddr == `DITD_ADDR_CTRL) begin
				ctrlReg <= {1'b0, pwdata[2:0]};
				// Clear loses to a simultaneous new conflict below
				if (pwdata[`DITD_CTRL_CLRWARN])
					paramConflictWarning <= 1'b0;
			end
			if (wrEn && paddr == `DITD_ADDR_MODE) begin
				if (pwdata[7:0] > `DITD_MODE_MAX || pwdata[31:8] != 24'h0) begin
				end else if (pwdata[7:0] == `DITD_MODE_THREE &&
						!mapped(`DITD_F_THREEWIRE, fnVec))
					paramConflictWarning <= 1'b1;
				else
					modeReg <= pwdata[7:0];
			end
			for (j = 0; j < 5; j = j + 1) begin
				if (wrEn && paddr == `DITD_ADDR_FUNC1 + 4 * j) begin
					// Function code out of range rejected
					if (pwdata[7:0] > `DITD_FUNC_MAX || pwdata[31:8] != 24'h0) begin
					end else if (modeReg == `DITD_MODE_THREE && fnMatch3w[j] &&
							pwdata[7:0] != `DITD_F_THREEWIRE &&
							(fnMatch3w & ~(5'h01 << j)) == 5'h00)
						paramConflictWarning <= 1'b1;
					else
						funcReg[j] <= pwdata[7:0];
				end
			end
		end
	end

	// Read data registered in the setup cycle
	always @(posedge mclk or negedge nrst) begin
		if (!nrst)
			prdata <= 32'h0;
		else if (rdEn) begin
			case (paddr)
			`DITD_ADDR_MODE:   prdata <= {24'h0, modeReg};
			`DITD_ADDR_FUNC1:  prdata <= {24'h0, funcReg[0]};
			`DITD_ADDR_FUNC2:  prdata <= {24'h0, funcReg[1]};
			`DITD_ADDR_FUNC3:  prdata <= {24'h0, funcReg[2]};
			`DITD_ADDR_FUNC4:  prdata <= {24'h0, funcReg[3]};
			`DITD_ADDR_FUNC5:  prdata <= {24'h0, funcReg[4]};
			`DITD_ADDR_CTRL:   prdata <= {28'h0, 1'b0, ctrlReg[2:0]};
			`DITD_ADDR_STATUS: prdata <= {26'h0, paramConflictWarning, externalFaultError,
				seqRunning, reverseDir, runCmd, 1'b0} | {27'h0, act};
			`DITD_ADDR_CMD:    prdata <= {16'h0, 1'b0, speedStep, 2'h0, rampSet,
				freqSource2, dcBrakeEnable, coastStop, rampStop, setpointZero,
				setpointDown, setpointUp, seqPause};
			default:           prdata <= 32'h0;
			endcase
		end
	end

	// Unmapped or reserved codes never match any lookup
	wire fwdIn  = anyFunc(`DITD_F_FWD, act, fnVec);
	wire revIn  = anyFunc(`DITD_F_REV, act, fnVec);
	// Stop terminal is closed-wired: open means stop
	wire stop3w = !anyFunc(`DITD_F_THREEWIRE, act, fnVec);
	wire faultIn = anyFunc(`DITD_F_EXTNO, act, fnVec) |
		(mapped(`DITD_F_EXTNC, fnVec) & ~anyFunc(`DITD_F_EXTNC, act, fnVec));
	wire coastIn = anyFunc(`DITD_F_COAST, act, fnVec);
	wire inhIn   = anyFunc(`DITD_F_SEQINH, act, fnVec);
	wire seqCfg  = ctrlReg[`DITD_CTRL_SEQCFG];

	reg  fwdPrevReg;
	reg  runNext;
	reg  revNext;

	// Run and direction decode per wiring mode
	always @* begin
		runNext = 1'b0;
		revNext = reverseDir;
		case (modeReg)
		`DITD_MODE_TWO_A: begin
			runNext = fwdIn ^ revIn;
			revNext = revIn & ~fwdIn;
		end
		`DITD_MODE_TWO_B: begin
			runNext = fwdIn;
			revNext = revIn;
		end
		`DITD_MODE_THREE: begin
			// Run latched on rising edge only
			runNext = stop3w ? 1'b0 : (runLevelReg | (fwdIn & ~fwdPrevReg));
			// Direction follows level even while running
			revNext = revIn;
		end
		default: begin
			runNext = 1'b0;
			revNext = reverseDir;
		end
		endcase
	end

	// Command outputs, all registered
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			runLevelReg <= 1'b0;
			fwdPrevReg <= 1'b0;
			runCmd <= 1'b0;
			reverseDir <= 1'b0;
			fwdLamp <= 1'b0;
			revLamp <= 1'b0;
			coastStop <= 1'b0;
			rampStop <= 1'b0;
			externalFaultError <= 1'b0;
			inhLatchReg <= 1'b0;
			seqRunReg <= 1'b0;
			seqRunning <= 1'b0;
			seqRestart <= 1'b0;
		end else begin
			fwdPrevReg <= fwdIn;
			// Fault is a stop while the terminal signals it
			externalFaultError <= faultIn;
			// Inhibit while sequencer runs latches a coast stop
			// Latch holds until a fresh run edge
			if (inhIn && seqRunning)
				inhLatchReg <= 1'b1;
			else if (!inhIn && runNext && !runLevelReg)
				inhLatchReg <= 1'b0;
			runLevelReg <= runNext & ~faultIn & ~coastIn;
			runCmd <= runNext & ~faultIn & ~coastIn & ~inhLatchReg;
			reverseDir <= revNext;
			// Both lamps lit on the conflict in wiring mode 0 only; other modes light one lamp
			fwdLamp <= (modeReg == `DITD_MODE_TWO_A) ? fwdIn : (runNext & ~revNext);
			revLamp <= (modeReg == `DITD_MODE_TWO_A) ? revIn : (runNext & revNext);
			coastStop <= coastIn | inhLatchReg | (inhIn & seqRunning);
			rampStop <= ~runNext & ~ctrlReg[`DITD_CTRL_STOPM];
			// Running only with config set and inhibit off
			seqRunning <= seqCfg & ~inhIn & runNext & ~inhLatchReg;
			// Run loss stops; next run starts at stage one
			seqRunReg <= runNext;
			seqRestart <= runNext & ~seqRunReg & seqCfg;
		end
	end

	// Selections and setpoint commands
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			speedStep <= 3'h0;
			rampSet <= 2'h0;
			setpointUp <= 1'b0;
			setpointDown <= 1'b0;
			setpointZero <= 1'b0;
			dcBrakeEnable <= 1'b0;
			seqPause <= 1'b0;
			freqSource2 <= 1'b0;
		end else begin
			// Index 0 means base reference and primary ramp
			speedStep <= {anyFunc(`DITD_F_STEP2, act, fnVec),
				anyFunc(`DITD_F_STEP1, act, fnVec), anyFunc(`DITD_F_STEP0, act, fnVec)};
			rampSet <= {anyFunc(`DITD_F_RAMP1, act, fnVec), anyFunc(`DITD_F_RAMP0, act, fnVec)};
			// Zero wins over up and down
			setpointZero <= anyFunc(`DITD_F_ZERO, act, fnVec);
			setpointUp <= anyFunc(`DITD_F_UP, act, fnVec) &
				~anyFunc(`DITD_F_DOWN, act, fnVec) & ~anyFunc(`DITD_F_ZERO, act, fnVec);
			setpointDown <= anyFunc(`DITD_F_DOWN, act, fnVec) &
				~anyFunc(`DITD_F_UP, act, fnVec) & ~anyFunc(`DITD_F_ZERO, act, fnVec);
			// DC brake only with ramp stop method
			dcBrakeEnable <= anyFunc(`DITD_F_DCBRAKE, act, fnVec) &
				~ctrlReg[`DITD_CTRL_STOPM];
			// Pause by level, drive holds zero without DC brake
			seqPause <= anyFunc(`DITD_F_SEQPAUSE, act, fnVec) & seqRunning;
			freqSource2 <= anyFunc(`DITD_F_FSRC2, act, fnVec);
		end
	end

endmodule // ditd_input_decoder
`default_nettype wire

// [ditd_switch_model.sv]
`timescale 1ns/100ps
`default_nettype none
// External contacts; sink wiring pulls the pin low when a contact closes
module ditd_switch_model (
	input  wire logic [4:0] swClosed,
	input  wire logic       activeLow,
	output var  logic [4:0] terminalIn
);
	assign terminalIn = activeLow ? ~swClosed : swClosed;
endmodule // ditd_switch_model
`default_nettype wire

// [ditd_decoder_chk.sv]
`timescale 1ns/100ps
`default_nettype none
`include "ditd_consts.vh"
// Pin watch; a stop output must never sit beside a run request for long
module ditd_decoder_chk (
	input wire logic        mclk,
	input wire logic        nrst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        runCmd,
	input wire logic        fwdLamp,
	input wire logic        revLamp,
	input wire logic        coastStop,
	input wire logic        rampStop,
	input wire logic        externalFaultError,
	input wire logic        seqRestart,
	input wire logic        paramConflictWarning
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	// Write access, and the one that clears the sticky warning
	wire logic wrAcc;
	wire logic clrWr;
	assign wrAcc = psel && penable && pwrite;
	assign clrWr = wrAcc && paddr == `DITD_ADDR_CTRL && pwdata[`DITD_CTRL_CLRWARN];
	AST_BOTH_LAMPS: assert property (fwdLamp && revLamp |-> !runCmd)
		else $error("both lamps lit with run");
	AST_COAST_STOP: assert property (coastStop |-> ##[0:2] !runCmd)
		else $error("coast without stop");
	AST_FAULT_STOP: assert property (externalFaultError [*3] |-> !runCmd)
		else $error("fault without stop");
	AST_RAMP_STOP: assert property (rampStop |-> !runCmd)
		else $error("ramp stop with run");
	AST_RESET_QUIET: assert property ($rose(nrst) |-> !runCmd && !coastStop)
		else $error("output active after reset");
	AST_RESTART_PULSE: assert property (seqRestart |=> !seqRestart)
		else $error("restart longer than a cycle");
	AST_WARN_STICKY: assert property (paramConflictWarning && !clrWr |=> paramConflictWarning)
		else $error("warning lost");
	AST_WARN_CAUSE: assert property ($rose(paramConflictWarning) |-> $past(wrAcc))
		else $error("warning without write");
	AST_READ_HOLD: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("read data moved");
	AST_ZERO_WAIT: assert property (psel && penable |-> pready && !pslverr)
		else $error("access not answered");
endmodule // ditd_decoder_chk
bind ditd_input_decoder ditd_decoder_chk i_ditd_decoder_chk (.mclk, .nrst, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .runCmd, .fwdLamp, .revLamp,
	.coastStop, .rampStop, .externalFaultError, .seqRestart, .paramConflictWarning);
`default_nettype wire

// [ditd_input_decoder_bench.sv]
`timescale 1ns/100ps
`default_nettype none
`include "ditd_consts.vh"
`define CHK(nm, e, g) begin totalChecks++; if ((g) !== (e)) begin nFail++; $display("Error %s expected %h seen %h", nm, e, g); end end
module ditd_input_decoder_bench;
	logic        mclk = 1'b0;
	logic        nrst = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, activeLow = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, prdata, rd;
	logic        pready, pslverr, runCmd, reverseDir, fwdLamp, revLamp, coastStop, seqRunning;
	logic        setpointUp, setpointDown, setpointZero, dcBrakeEnable, seqPause, freqSource2;
	logic        externalFaultError, paramConflictWarning, rampStop;
	logic [2:0]  speedStep;
	logic [1:0]  rampSet;
	logic [4:0]  swClosed = 5'h00, terminalIn;
	logic [7:0]  obs;
	int          nFail = 0, totalChecks = 0;
	// Terminal five codes and the pins expected while its contact is closed
	logic [7:0]  fc [14] = '{8'h00, 8'h04, 8'h0c, 8'h0e, 8'h11, 8'h09, 8'h0a, 8'h0b, 8'h0d,
		8'h10, 8'h12, 8'h08, 8'h13, 8'h14};
	logic [7:0]  fx [14] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h08, 8'h10, 8'h40,
		8'h02, 8'h80, 8'h20, 8'h01, 8'h00};
	// Run and direction, two bits per switch pair, wiring modes 0 and 1
	logic [7:0]  runTbl [2] = '{8'h38, 8'hc8};
	assign obs = {freqSource2, dcBrakeEnable, coastStop, setpointZero, setpointDown, setpointUp,
		seqPause, externalFaultError};
	always #2 mclk = ~mclk;
	ditd_switch_model i_ditd_switch_model (.swClosed, .activeLow, .terminalIn);
	ditd_input_decoder i_ditd_input_decoder (.mclk, .nrst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .terminalIn, .runCmd, .reverseDir, .fwdLamp,
		.revLamp, .coastStop, .rampStop, .speedStep, .rampSet, .setpointUp, .setpointDown,
		.setpointZero, .dcBrakeEnable, .seqRunning, .seqPause, .seqRestart(), .freqSource2,
		.externalFaultError, .paramConflictWarning);
	// One APB transfer, held until pready is seen high at a rising edge
	task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge mclk);
	endtask
	task rchk(input logic [11:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h00);
		`CHK("register", e, rd[7:0])
	endtask
	// Contacts change, then wait out sync plus the 250-cycle debounce
	task sw(input logic [4:0] v);
		@(posedge mclk);
		swClosed <= v;
		repeat (260) @(posedge mclk);
		@(negedge mclk);
	endtask
	task printVerdict;
		$display("checks %0d errors %0d", totalChecks, nFail);
		if (nFail == 0 && totalChecks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Hang guard, well above the roughly 16000 cycles the sequence needs
	initial begin
		repeat (40000) @(posedge mclk);
		nFail++;
		printVerdict();
	end
	initial begin
		repeat (6) @(posedge mclk);
		nrst <= 1'b1;
		for (int i = 0; i < 6; i++) rchk(12'(i * 4), `DITD_RST_VAL);
		apb(1'b1, `DITD_ADDR_MODE, 8'h03);
		apb(1'b1, `DITD_ADDR_FUNC1, 8'h1d);
		apb(1'b1, 12'h030, 8'h01);
		rchk(`DITD_ADDR_MODE, 8'h00);
		rchk(`DITD_ADDR_FUNC1, 8'h00);
		apb(1'b1, `DITD_ADDR_FUNC1, `DITD_FUNC_MAX);
		rchk(`DITD_ADDR_FUNC1, 8'h1c);
		apb(1'b1, `DITD_ADDR_MODE, `DITD_MODE_THREE);
		rchk(`DITD_ADDR_MODE, 8'h00);
		`CHK("warning", 1'b1, paramConflictWarning)
		apb(1'b1, `DITD_ADDR_CTRL, 8'h08);
		`CHK("warning", 1'b0, paramConflictWarning)
		// Two-wire modes over every switch pair
		apb(1'b1, `DITD_ADDR_FUNC1, `DITD_F_FWD);
		apb(1'b1, `DITD_ADDR_FUNC2, `DITD_F_REV);
		for (int m = 0; m < 2; m++) begin
			apb(1'b1, `DITD_ADDR_MODE, 8'(m));
			for (int v = 0; v < 4; v++) begin
				sw(5'(v));
				`CHK("run", runTbl[m][2*v+:2], ({runCmd, runCmd & reverseDir}))
				if (m == 0 && v == 3) `CHK("lamps", 2'b11, ({fwdLamp, revLamp}))
			end
		end
		apb(1'b1, `DITD_ADDR_MODE, `DITD_MODE_TWO_A);
		apb(1'b1, `DITD_ADDR_FUNC3, `DITD_F_STEP0);
		apb(1'b1, `DITD_ADDR_FUNC4, `DITD_F_STEP1);
		apb(1'b1, `DITD_ADDR_FUNC5, `DITD_F_STEP2);
		for (int s = 0; s < 8; s++) begin
			sw({3'(s), 2'b01});
			`CHK("speed step", 3'(s), speedStep)
		end
		apb(1'b1, `DITD_ADDR_FUNC3, `DITD_F_RAMP0);
		apb(1'b1, `DITD_ADDR_FUNC4, `DITD_F_RAMP1);
		apb(1'b1, `DITD_ADDR_FUNC5, `DITD_F_NONE);
		for (int s = 0; s < 4; s++) begin
			sw({1'b0, 2'(s), 2'b01});
			`CHK("ramp set", 2'(s), rampSet)
		end
		// Single-terminal functions while running forward, sequencer configured
		apb(1'b1, `DITD_ADDR_FUNC3, `DITD_F_NONE);
		apb(1'b1, `DITD_ADDR_FUNC4, `DITD_F_NONE);
		apb(1'b1, `DITD_ADDR_CTRL, 8'h04);
		for (int k = 0; k < 14; k++) begin
			apb(1'b1, `DITD_ADDR_FUNC5, fc[k]);
			sw(5'h11);
			`CHK("closed", fx[k], obs)
			// Command word: same flags, ramp stop clear while running
			rchk(`DITD_ADDR_CMD, {fx[k][7:5], 1'b0, fx[k][4:1]});
			sw(5'h01);
			`CHK("open", ({7'h00, fc[k] == `DITD_F_EXTNC}), obs)
		end
		// DC brake request ignored when the stop method is not ramp
		apb(1'b1, `DITD_ADDR_FUNC5, `DITD_F_DCBRAKE);
		apb(1'b1, `DITD_ADDR_CTRL, 8'h06);
		sw(5'h11);
		`CHK("brake other stop", 1'b0, dcBrakeEnable)
		apb(1'b1, `DITD_ADDR_FUNC5, `DITD_F_EXTNO);
		apb(1'b1, `DITD_ADDR_CTRL, 8'h05);
		@(posedge mclk);
		activeLow <= 1'b1;
		sw(5'h11);
		`CHK("inverted fault", 1'b1, externalFaultError)
		apb(1'b1, `DITD_ADDR_CTRL, 8'h04);
		@(posedge mclk);
		activeLow <= 1'b0;
		sw(5'h01);
		apb(1'b1, `DITD_ADDR_FUNC5, `DITD_F_SEQINH);
		`CHK("sequencer", 1'b1, seqRunning)
		sw(5'h11);
		`CHK("inhibit", 2'b01, ({seqRunning, coastStop}))
		sw(5'h01);
		`CHK("standstill", 1'b0, runCmd)
		sw(5'h00);
		sw(5'h01);
		`CHK("rerun", 2'b11, ({runCmd, seqRunning}))
		// A 100-cycle contact glitch must not pass the debounce
		@(posedge mclk);
		swClosed <= 5'h03;
		repeat (100) @(posedge mclk);
		@(negedge mclk);
		`CHK("glitch", 1'b1, runCmd)
		sw(5'h01);
		// Three-wire control
		apb(1'b1, `DITD_ADDR_FUNC3, `DITD_F_THREEWIRE);
		apb(1'b1, `DITD_ADDR_FUNC5, `DITD_F_NONE);
		sw(5'h04);
		apb(1'b1, `DITD_ADDR_MODE, `DITD_MODE_THREE);
		rchk(`DITD_ADDR_MODE, 8'h02);
		sw(5'h05);
		`CHK("three-wire run", 2'b10, ({runCmd, reverseDir}))
		sw(5'h04);
		`CHK("run latched", 1'b1, runCmd)
		sw(5'h06);
		`CHK("reversed", 2'b11, ({runCmd, reverseDir}))
		sw(5'h02);
		`CHK("stopped", 1'b0, runCmd)
		`CHK("ramp stop", 1'b1, rampStop)
		apb(1'b1, `DITD_ADDR_FUNC3, `DITD_F_NONE);
		rchk(`DITD_ADDR_FUNC3, `DITD_F_THREEWIRE);
		`CHK("warning", 1'b1, paramConflictWarning)
		// Status: warning, reverse direction, terminal two level
		rchk(`DITD_ADDR_STATUS, 8'h26);
		printVerdict();
	end
endmodule // ditd_input_decoder_bench
`default_nettype wire
